// ==== rtl/arr_pkg.sv ====
// Package of offsets, widths and reset values for the result register bank.
package arr_pkg;

	// ==========================================================
	// Register offsets
	localparam logic [7:0] OFS_CHARGE_CURRENT_LOW = 8'h1A;
	localparam logic [7:0] OFS_BUS_VOLTAGE_HIGH = 8'h1B;
	localparam logic [7:0] OFS_BUS_VOLTAGE_LOW = 8'h1C;
	localparam logic [7:0] OFS_BATTERY_VOLTAGE_HIGH = 8'h1D;
	localparam logic [7:0] OFS_BATTERY_VOLTAGE_LOW = 8'h1E;
	localparam logic [7:0] OFS_TOP_CELL_VOLTAGE_HIGH = 8'h1F;

	// ==========================================================
	// Field layout and reset values
	localparam int RESULT_WIDTH = 16;
	localparam int SIGN_BIT = 15;
	localparam int HIGH_BYTE_LSB = 8;
	localparam logic [7:0] RESULT_RESET = 8'h00;
	localparam logic [15:0] WORD_RESET = 16'h0000;

	// ==========================================================
	// Result channel selector
	typedef enum logic [1:0] {
		CH_CHARGE_CURRENT,
		CH_BUS_VOLTAGE,
		CH_BATTERY_VOLTAGE,
		CH_TOP_CELL_VOLTAGE
	} arr_channel_t;

endpackage

// ==== rtl/arr_word_store.sv ====
// Small memory of result words with a registered read port.
`timescale 1ns/1ps
module arr_word_store #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic clearAll,
	// Write port
	input wire logic wrEn,
	input wire logic [$clog2(DEPTH)-1:0] wrAddr,
	input wire logic [WIDTH-1:0] wrData,
	// Read port
	input wire logic [$clog2(DEPTH)-1:0] rdAddr,
	output logic [WIDTH-1:0] rdData
);

	initial begin
		if (WIDTH < 1 || DEPTH < 2) begin
			$error("arr_word_store: unsupported size");
		end
	end

	logic [WIDTH-1:0] mem [DEPTH];

	// Words are written whole, so both halves of a sample change together.
	always_ff @(posedge sys_clk) begin
		for (int i = 0; i < DEPTH; i++) begin
			if (sys_rst || clearAll) begin
				mem[i] <= '0;
			end else if (wrEn && wrAddr == i[$clog2(DEPTH)-1:0]) begin
				mem[i] <= wrData;
			end
		end
	end

	// Read data comes from a register.
	always_ff @(posedge sys_clk) begin
		if (sys_rst || clearAll) begin
			rdData <= '0;
		end else begin
			rdData <= mem[rdAddr];
		end
	end

endmodule

// ==== rtl/arr_result_bank.sv ====
// Read-only bank of converter result registers on the serial register port.
// Contract
// - Bus and battery voltage results are signed 16-bit words, bit 15 sign.
// - Bus voltage high byte at 1Bh, low byte at 1Ch, 1 mV steps.
// - Bus voltage low byte weights 128 mV down to 1 mV.
// - Battery voltage high byte at 1Dh, bit 7 sign.
// - Battery voltage low byte at 1Eh, 1 mV per step.
// - Charge current low byte is read-only, 1 mA per step.
// - Top-cell voltage high byte at 1Fh holds bits 15:8, resets to zero.
// - All results read-only, cleared by register reset, kept on watchdog expiry.
`timescale 1ns/1ps
module arr_result_bank #(
	parameter int RESULT_WIDTH = arr_pkg::RESULT_WIDTH
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Register reset command and watchdog expiry
	input wire logic regResetCmd,
	input wire logic watchdogExpired,
	// Converter result delivery
	input wire logic resultValid,
	input wire logic [1:0] resultChannel,
	input wire logic [RESULT_WIDTH-1:0] resultWord,
	// Register read port
	input wire logic rdStrobe,
	input wire logic [7:0] rdAddr,
	output logic [7:0] rdData,
	output logic rdValid,
	output logic rdHit
);

	// ==========================================================
	// Elaboration check
	initial begin
		if (RESULT_WIDTH != 16) begin
			$error("arr_result_bank: result words must be 16 bits");
		end
	end

	// ==========================================================
	// Address decode
	// Each mapped offset selects a word and a byte half.
	wire isCurLow = (rdAddr == arr_pkg::OFS_CHARGE_CURRENT_LOW);
	wire isBusHigh = (rdAddr == arr_pkg::OFS_BUS_VOLTAGE_HIGH);
	wire isBusLow = (rdAddr == arr_pkg::OFS_BUS_VOLTAGE_LOW);
	wire isBatHigh = (rdAddr == arr_pkg::OFS_BATTERY_VOLTAGE_HIGH);
	wire isBatLow = (rdAddr == arr_pkg::OFS_BATTERY_VOLTAGE_LOW);
	wire isTopHigh = (rdAddr == arr_pkg::OFS_TOP_CELL_VOLTAGE_HIGH);
	wire addrHit = isCurLow | isBusHigh | isBusLow | isBatHigh | isBatLow | isTopHigh;

	// Word selection for the store read port.
	logic [1:0] rdWord;
	always_comb begin
		if (isBusHigh || isBusLow) begin
			rdWord = 2'(arr_pkg::CH_BUS_VOLTAGE);
		end else if (isBatHigh || isBatLow) begin
			rdWord = 2'(arr_pkg::CH_BATTERY_VOLTAGE);
		end else if (isTopHigh) begin
			rdWord = 2'(arr_pkg::CH_TOP_CELL_VOLTAGE);
		end else begin
			rdWord = 2'(arr_pkg::CH_CHARGE_CURRENT);
		end
	end

	wire wantHigh = isBusHigh | isBatHigh | isTopHigh;

	// ==========================================================
	// Result storage
	// A register reset clears all results; watchdog expiry is not a clear.
	wire clearAll = regResetCmd;
	logic [RESULT_WIDTH-1:0] storeWord;

	// The whole 16-bit word is written in one cycle, high and low together.
	arr_word_store #(
		.WIDTH(RESULT_WIDTH),
		.DEPTH(4)
	) uStore (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.clearAll(clearAll),
		.wrEn(resultValid),
		.wrAddr(resultChannel),
		.wrData(resultWord),
		.rdAddr(rdWord),
		.rdData(storeWord)
	);

	// ==========================================================
	// Read pipeline
	// Strobe, byte half and hit are delayed to line up with the store output.
	logic stbDly_reg;
	logic highDly_reg;
	logic hitDly_reg;
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			stbDly_reg <= 1'b0;
			highDly_reg <= 1'b0;
			hitDly_reg <= 1'b0;
		end else begin
			stbDly_reg <= rdStrobe;
			highDly_reg <= wantHigh;
			hitDly_reg <= addrHit;
		end
	end

	// Byte out of the selected word; unmapped offsets read zero.
	wire [7:0] byteSel = highDly_reg ? storeWord[RESULT_WIDTH-1:arr_pkg::HIGH_BYTE_LSB]
		: storeWord[arr_pkg::HIGH_BYTE_LSB-1:0];
	logic [7:0] rdData_next;
	assign rdData_next = hitDly_reg ? byteSel : arr_pkg::RESULT_RESET;

	// Data output register, captured on the delayed strobe and held after.
	always_ff @(posedge sys_clk) begin
		if (sys_rst || clearAll) begin
			rdData <= arr_pkg::RESULT_RESET;
			rdValid <= 1'b0;
			rdHit <= 1'b0;
		end else begin
			rdValid <= stbDly_reg;
			if (stbDly_reg) begin
				rdData <= rdData_next;
				rdHit <= hitDly_reg;
			end
		end
	end

	// The watchdog input is intentionally unused: results survive its expiry.
	wire unusedWatchdog = watchdogExpired;

endmodule

// ==== tb/arr_result_bank_chk.sv ====
// Port checker for the result register bank.
`timescale 1ns/1ps
module arr_result_bank_chk (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Result side and read port
	input wire logic regResetCmd,
	input wire logic resultValid,
	input wire logic [1:0] resultChannel,
	input wire logic [15:0] resultWord,
	input wire logic rdStrobe,
	input wire logic [7:0] rdAddr,
	input wire logic [7:0] rdData,
	input wire logic rdValid,
	input wire logic rdHit
);
	// Keeps the last delivered word so a read can be tied to it.
	logic [15:0] lastWord;
	wire [7:0] lastHi = lastWord[15:8];
	wire [7:0] lastLo = lastWord[7:0];
	wire quiet = !resultValid && !regResetCmd;
	always_ff @(posedge sys_clk) if (resultValid) lastWord <= resultWord;
	// ============
	// Assertions
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	a_valid_latency: assert property (rdValid == $past(rdStrobe, 2))
		else $error("read answer timing wrong");
	a_hit_map: assert property (rdValid |-> rdHit == ($past(rdAddr, 2) inside {[8'h1A:8'h1F]}))
		else $error("hit flag wrong");
	a_miss_zero: assert property (rdValid && !rdHit |-> rdData == 8'h00)
		else $error("unmapped read not zero");
	a_data_hold: assert property (!rdValid && !$past(regResetCmd) |-> $stable(rdData))
		else $error("read data moved");
	a_clear_read: assert property (regResetCmd ##1 quiet ##1 (quiet && rdStrobe) ##1 quiet
		|-> ##1 rdData == 8'h00) else $error("result not cleared");
	a_bus_high: assert property (resultValid && resultChannel == 2'h1
		##1 (quiet && rdStrobe && rdAddr == 8'h1B) ##1 quiet |-> ##1 rdData == $past(lastHi, 2))
		else $error("bus high byte wrong");
	a_bat_low: assert property (resultValid && resultChannel == 2'h2
		##1 (quiet && rdStrobe && rdAddr == 8'h1E) ##1 quiet |-> ##1 rdData == $past(lastLo, 2))
		else $error("battery low byte wrong");
	a_top_high: assert property (resultValid && resultChannel == 2'h3
		##1 (quiet && rdStrobe && rdAddr == 8'h1F) ##1 quiet |-> ##1 rdData == $past(lastHi, 2))
		else $error("top-cell high byte wrong");
endmodule
bind arr_result_bank arr_result_bank_chk i_chk (.sys_clk, .sys_rst, .regResetCmd, .resultValid,
	.resultChannel, .resultWord, .rdStrobe, .rdAddr, .rdData, .rdValid, .rdHit);

// ==== tb/arr_conv_model.sv ====
// Converter stand-in that delivers result words to the bank.
`timescale 1ns/1ps
module arr_conv_model (
	// Clock and request
	input wire logic sys_clk,
	input wire logic go,
	input wire logic [1:0] ch,
	input wire logic [15:0] word,
	// Result delivery
	output logic resultValid,
	output logic [1:0] resultChannel,
	output logic [15:0] resultWord
);
	// Delivers a whole word in one pulse; the word lines wander when idle.
	always_ff @(posedge sys_clk) begin
		resultValid <= go;
		resultChannel <= ch;
		resultWord <= go ? word : ~word;
	end
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench for the result register bank.
`timescale 1ns/1ps
module testbench;
	logic sys_clk = 0, sys_rst = 1, regResetCmd = 0, watchdogExpired = 0, go = 0, rdStrobe = 0;
	logic [1:0] ch = 0;
	logic [15:0] word = 0, v[4] = '{default: 16'h0000};
	logic [7:0] rdAddr = 0, probe[4] = '{8'h1A, 8'h1B, 8'h1E, 8'h1F};
	logic [8:0] e, expq[$];
	wire resultValid, rdValid, rdHit;
	wire [1:0] resultChannel;
	wire [15:0] resultWord;
	wire [7:0] rdData;
	int num_errors = 0, n_checks = 0, cyc = 0;
	// Clock and cycle ceiling.
	always #2.5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) if (++cyc == 1000) begin
		num_errors++;
		$display("Error at %0t: cycle ceiling reached", $time);
		results();
	end
	// Converter stand-in and the bank.
	arr_conv_model i_conv (.sys_clk, .go, .ch, .word, .resultValid, .resultChannel, .resultWord);
	arr_result_bank i_dut (.sys_clk, .sys_rst, .regResetCmd, .watchdogExpired, .resultValid,
		.resultChannel, .resultWord, .rdStrobe, .rdAddr, .rdData, .rdValid, .rdHit);
	// Compares each answer with the oldest expected byte.
	always @(negedge sys_clk) if (rdValid === 1'b1) begin
		n_checks++;
		e = expq.pop_front();
		if ({rdHit, rdData} !== e) begin
			num_errors++;
			$display("Error at %0t: hit and read %h, expected %h", $time, {rdHit, rdData}, e);
		end
	end
	function automatic logic [7:0] ex(input logic [7:0] a);
		logic [7:0] i;
		i = a - 8'h1A;
		return (i > 8'h05) ? 8'h00 : i[0] ? v[(i + 1) >> 1][15:8] : v[(i + 1) >> 1][7:0];
	endfunction
	task rd(input logic [7:0] a);
		@(posedge sys_clk);
		rdStrobe <= 1'b1;
		rdAddr <= a;
		expq.push_back({(a >= 8'h1A && a <= 8'h1F), ex(a)});
	endtask
	task wr(input logic [1:0] c);
		@(posedge sys_clk);
		go <= 1'b1;
		ch <= c;
		word <= v[c];
		@(posedge sys_clk);
		go <= 1'b0;
		rd(probe[c]);
		@(posedge sys_clk);
		rdStrobe <= 1'b0;
	endtask
	task scan();
		for (logic [7:0] a = 8'h19; a <= 8'h20; a++) rd(a);
		@(posedge sys_clk);
		rdStrobe <= 1'b0;
		repeat (3) @(posedge sys_clk);
		$display("Scan ended at %0t", $time);
	endtask
	task results();
		$display("Checks %0d, mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// Reset, scan, deliver, scan, then watchdog and register reset, each followed by a scan.
	initial begin
		void'($urandom(47));
		repeat (5) @(posedge sys_clk);
		sys_rst <= 1'b0;
		scan();
		for (int c = 0; c < 4; c++) begin
			v[c] = 16'($urandom);
			if (c == 1) v[c][15] = 1'b1;
			wr(c[1:0]);
		end
		scan();
		@(posedge sys_clk) watchdogExpired <= 1'b1;
		@(posedge sys_clk) watchdogExpired <= 1'b0;
		scan();
		@(posedge sys_clk) regResetCmd <= 1'b1;
		@(posedge sys_clk) regResetCmd <= 1'b0;
		v = '{default: 16'h0000};
		scan();
		if (expq.size() != 0) begin
			num_errors++;
			$display("Error at %0t: %0d answers missing", $time, expq.size());
		end
		results();
	end
endmodule
